// [meq_checker_assertions.sv]
// port-level assertion checker for the event queue block
`timescale 1ns/100ps
module meq_checker (
    // clock, reset and apb answer
    input wire        pclk, presetn, psel, penable, pready, pslverr,
    // channel request and fault side
    input wire [4:0]  ch_num,
    input wire        ch_ack, tx_fifo_underrun, rx_fifo_overrun, tx_enable, rx_enable,
    input wire        rx_mem_write_en, mem_req, mem_we, mem_ack,
    // queue memory port
    input wire [31:0] mem_addr,
    input wire [15:0] mem_wdata, mem_rdata
);
    // ----------------------------------------------------------------
    // all checks live in the one clock domain
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("slave error without ready");
    property p_gun; tx_fifo_underrun |=> !tx_enable; endproperty
    a_gun: assert property (p_gun) else $error("transmit kept after underrun");
    property p_gov; rx_fifo_overrun |=> !rx_enable && !rx_mem_write_en; endproperty
    a_gov: assert property (p_gov) else $error("receive kept after overrun");
    property p_rxk; tx_fifo_underrun && !rx_fifo_overrun && rx_enable |=> rx_enable; endproperty
    a_rxk: assert property (p_rxk) else $error("receive hit by underrun");
    // a memory request must not wander before it is answered
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("memory request changed");
    property p_ack; ch_ack |=> !ch_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack longer than a cycle");
    property p_val; mem_req && mem_we |-> mem_wdata[0] && !mem_wdata[4]; endproperty
    a_val: assert property (p_val) else $error("entry written invalid");
    property p_ch; mem_req && mem_we |-> mem_wdata[9:5] == ch_num; endproperty
    a_ch: assert property (p_ch) else $error("entry channel wrong");
    // a slot found still valid must not be written in the three cycles after its read is answered
    property p_ovf; mem_ack && mem_req && !mem_we && mem_rdata[0] |=> !mem_we [*3]; endproperty
    a_ovf: assert property (p_ovf) else $error("valid slot overwritten");
endmodule
bind meq_top meq_checker i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .ch_num, .ch_ack, .tx_fifo_underrun, .rx_fifo_overrun, .tx_enable, .rx_enable,
    .rx_mem_write_en, .mem_req, .mem_we, .mem_ack, .mem_addr, .mem_wdata, .mem_rdata);

// [meq_defines.vh]
// shared offsets, field positions, reset values and timing counts for the event queue block
`ifndef MEQ_DEFINES_VH
`define MEQ_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses on the apb bus
// ----------------------------------------------------------------
`define MEQ_OFS_EVENT        12'h000
`define MEQ_OFS_MASK         12'h004
`define MEQ_OFS_QBASE        12'h008
`define MEQ_OFS_QPTR         12'h00c
`define MEQ_OFS_QMASK        12'h010
`define MEQ_OFS_CTRL         12'h014
`define MEQ_OFS_STATUS       12'h018

// ----------------------------------------------------------------
// event and mask register fields
// ----------------------------------------------------------------
`define MEQ_EV_QOVF          4
`define MEQ_EV_NEW           5
`define MEQ_EV_GUN           6
`define MEQ_EV_GOV           7
`define MEQ_EV_IMPL          16'h00f0
`define MEQ_EV_W1C           16'h00e0
`define MEQ_EV_RST           16'h0000
`define MEQ_MASK_RST         16'h0000

// ----------------------------------------------------------------
// queue entry fields
// ----------------------------------------------------------------
`define MEQ_QE_VALID         0
`define MEQ_QE_WRAP          1
`define MEQ_QE_NID           2
`define MEQ_QE_IDL           3
`define MEQ_QE_CH_LO         5
`define MEQ_QE_CH_HI         9
`define MEQ_QE_MRF           10
`define MEQ_QE_UN            11
`define MEQ_QE_EV_LO         10
`define MEQ_QE_EV_HI         15
`define MEQ_QMASK_RST        16'hfc0c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define MEQ_CTRL_TX_RESTART  0
`define MEQ_CTRL_RX_RESTART  1
`define MEQ_CTRL_TRANSP      2

// ----------------------------------------------------------------
// queue memory timing
// ----------------------------------------------------------------
`define MEQ_MEM_TIMEOUT_NS   1000
`define MEQ_MEM_TIMEOUT_CYC  ((`MEQ_MEM_TIMEOUT_NS) / 50)
`define MEQ_QSIZE_MAX        17'h10000

`endif

// [meq_entry_writer.v]
// writes one queue entry into external memory, checking the slot first
`timescale 1ns/100ps
`include "meq_defines.vh"
module meq_entry_writer #(
    parameter AW = 32
) (
    // clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // request from the controller
    input  wire          req_i,
    input  wire [AW-1:0] addr_i,
    input  wire [15:0]   entry_i,
    output reg           busy_o,
    output reg           done_o,
    output reg           ovf_o,
    output reg           wrap_o,
    // external memory port
    output reg           mem_req_o,
    output reg           mem_we_o,
    output reg  [AW-1:0] mem_addr_o,
    output reg  [15:0]   mem_wdata_o,
    input  wire          mem_ack_i,
    input  wire [15:0]   mem_rdata_i
);
    localparam S_IDLE  = 2'd0;
    localparam S_READ  = 2'd1;
    localparam S_WRITE = 2'd2;

    reg [1:0] state_q;

    // ----------------------------------------------------------------
    // read slot, then write only if the host has released it
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= S_IDLE;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            ovf_o       <= 1'b0;
            wrap_o      <= 1'b0;
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= {AW{1'b0}};
            mem_wdata_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            ovf_o  <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (req_i) begin
                        busy_o     <= 1'b1;
                        mem_req_o  <= 1'b1;
                        mem_we_o   <= 1'b0;
                        mem_addr_o <= addr_i;
                        state_q    <= S_READ;
                    end
                end
                S_READ: begin
                    if (mem_ack_i) begin
                        wrap_o <= mem_rdata_i[`MEQ_QE_WRAP];
                        if (mem_rdata_i[`MEQ_QE_VALID]) begin
                            // slot still owned by host: drop entry, keep slot
                            mem_req_o <= 1'b0;
                            ovf_o     <= 1'b1;
                            busy_o    <= 1'b0;
                            state_q   <= S_IDLE;
                        end else begin
                            // keep the slot's wrap bit, mark entry valid
                            mem_we_o    <= 1'b1;
                            mem_wdata_o <= entry_i
                                         | (mem_rdata_i & (16'h0001 << `MEQ_QE_WRAP))
                                         | (16'h0001 << `MEQ_QE_VALID);
                            state_q     <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o  <= 1'b0;
                        done_o    <= 1'b1;
                        busy_o    <= 1'b0;
                        state_q   <= S_IDLE;
                    end
                end
                default: begin
                    state_q   <= S_IDLE;
                    mem_req_o <= 1'b0;
                    busy_o    <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [meq_sticky_flags.v]
// sticky event flags with write-one-to-clear, set wins over clear
`timescale 1ns/100ps
module meq_sticky_flags #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // hardware sets and software clears
    input  wire [WIDTH-1:0] set_i,
    input  wire [WIDTH-1:0] clr_i,
    input  wire [WIDTH-1:0] impl_i,
    // flag state
    output wire [WIDTH-1:0] flags_o
);
    reg [WIDTH-1:0] flags_q;

    // ----------------------------------------------------------------
    // one flop per bit, generated
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // set listed ahead of clear in priority so an event during a clear is kept
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags_q[i] <= 1'b0;
                end else if (!impl_i[i]) begin
                    flags_q[i] <= 1'b0;
                end else if (set_i[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clr_i[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags_o = flags_q;
endmodule

// [meq_top.v]
// event register, mask, and circular queue writer for a multichannel serial controller
//
// What this block does
// - mask bit zero keeps its flag from raising any interrupt request.
// - mask bit one lets a set flag drive the channel pending output.
// - event word: bits 0-3 reserved, 4 overflow, 5 new, 6 underrun, 7 overrun.
// - writing into a slot still valid sets overflow flag; with mask enabled it requests interrupt.
// - on overflow the new entry is dropped, no slot overwritten.
// - new-entry flag set whenever an entry was written to the queue.
// - new, underrun, overrun flags cleared by writing one; zero leaves them.
// - global tx underrun sets flag, halts all transmit, tx line idles.
// - transmit resumes only after host reinitialises transmitting channels.
// - underrun flag with mask enabled raises interrupt request.
// - global rx overrun sets flag, halts reception and memory writes.
// - receive resumes after host reinit; overrun with mask raises request.
// - entry: valid, wrap, nid, idle, rsvd, channel 5-9, events 10-15.
// - device sets the valid bit of each entry it writes.
// - wrap bit marks last entry; next access returns to queue base.
// - not-idle event reported on non-idle pattern, never in transparent mode.
// - idle event reported on first idle after non-idle, not in transparent.
// - channel number field five bits, channels 0 to 31.
// - after writing an entry, advance pointer; wrap entry returns it to base.
// - channel interrupt enters queue only if it passes the queue entry mask.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`include "meq_defines.vh"
module meq_top #(
    parameter AW = 32
) (
    // clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // apb slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // channel event requests from the serial engine
    input  wire          ch_req,
    input  wire [4:0]    ch_num,
    input  wire [5:0]    ch_events,
    input  wire          ch_non_idle,
    input  wire          ch_idle,
    output reg           ch_ack,
    // global fifo faults
    input  wire          tx_fifo_underrun,
    input  wire          rx_fifo_overrun,
    // engine control
    output reg           tx_enable,
    output reg           rx_enable,
    output reg           rx_mem_write_en,
    output reg           pending,
    // external queue memory
    output reg           mem_req,
    output reg           mem_we,
    output reg  [AW-1:0] mem_addr,
    output reg  [15:0]   mem_wdata,
    input  wire          mem_ack,
    input  wire [15:0]   mem_rdata
);
    // ----------------------------------------------------------------
    // address decode helper
    // ----------------------------------------------------------------
    function is_reg;
        input [11:0] a;
        input [11:0] ofs;
        begin
            is_reg = (a == ofs);
        end
    endfunction

    localparam Q_IDLE = 2'd0;
    localparam Q_BUSY = 2'd1;
    localparam Q_ACK  = 2'd2;

    reg  [15:0]   mask_q;
    reg  [AW-1:0] qbase_q;
    reg  [AW-1:0] qptr_q;
    reg  [15:0]   qmask_q;
    reg           transp_q;
    reg  [1:0]    qstate_q;
    reg  [15:0]   entry_q;
    reg  [4:0]    last_ch_q;
    reg           ovf_seen_q;
    wire [15:0]   flags;
    wire [15:0]   ev_set;
    wire [15:0]   ev_clr;
    wire          wr_acc;
    wire          rd_setup;
    wire          wr_busy;
    wire          wr_done;
    wire          wr_ovf;
    wire          wr_wrap;
    wire          w_req;
    wire          w_we;
    wire [AW-1:0] w_addr;
    wire [15:0]   w_wdata;
    wire          ctrl_wr;
    reg  [15:0]   entry_d;
    reg           entry_pass;

    // ----------------------------------------------------------------
    // apb strobes
    // ----------------------------------------------------------------
    // zero wait states: pready is high in every access phase
    assign wr_acc   = psel & penable & pwrite & pready;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign ctrl_wr  = wr_acc & is_reg(paddr, `MEQ_OFS_CTRL);

    // ----------------------------------------------------------------
    // event flag sources and clears
    // ----------------------------------------------------------------
    assign ev_set = ({15'h0000, wr_ovf} << `MEQ_EV_QOVF)
                  | ({15'h0000, wr_done} << `MEQ_EV_NEW)
                  | ({15'h0000, tx_fifo_underrun} << `MEQ_EV_GUN)
                  | ({15'h0000, rx_fifo_overrun} << `MEQ_EV_GOV);
    // overflow bit is also cleared by writing one, so software can recover
    assign ev_clr = (wr_acc & is_reg(paddr, `MEQ_OFS_EVENT))
                  ? (pwdata[15:0] & `MEQ_EV_IMPL) : 16'h0000;

    meq_sticky_flags #(
        .WIDTH (16)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set_i   (ev_set),
        .clr_i   (ev_clr),
        .impl_i  (`MEQ_EV_IMPL),
        .flags_o (flags)
    );

    // ----------------------------------------------------------------
    // queue entry writer
    // ----------------------------------------------------------------
    meq_entry_writer #(
        .AW (AW)
    ) u_writer (
        .pclk        (pclk),
        .presetn     (presetn),
        .req_i       (qstate_q == Q_IDLE && ch_req && !ch_ack && entry_pass),
        .addr_i      (qptr_q),
        .entry_i     (entry_q),
        .busy_o      (wr_busy),
        .done_o      (wr_done),
        .ovf_o       (wr_ovf),
        .wrap_o      (wr_wrap),
        .mem_req_o   (w_req),
        .mem_we_o    (w_we),
        .mem_addr_o  (w_addr),
        .mem_wdata_o (w_wdata),
        .mem_ack_i   (mem_ack),
        .mem_rdata_i (mem_rdata)
    );

    // ----------------------------------------------------------------
    // entry assembly and queue mask
    // ----------------------------------------------------------------
    always @* begin
        entry_d = 16'h0000;
        entry_d[`MEQ_QE_CH_HI:`MEQ_QE_CH_LO] = ch_num;
        entry_d[`MEQ_QE_EV_HI:`MEQ_QE_EV_LO] = ch_events;
        entry_d[`MEQ_QE_NID] = ch_non_idle & ~transp_q;
        entry_d[`MEQ_QE_IDL] = ch_idle & ~transp_q;
        // frame-too-long is an hdlc-only event as well
        if (transp_q) begin
            entry_d[`MEQ_QE_MRF] = 1'b0;
        end
        entry_d = entry_d & (qmask_q | (16'h001f << `MEQ_QE_CH_LO));
        entry_pass = |(entry_d & ~(16'h0001 << `MEQ_QE_VALID)
                             & ~(16'h0001 << `MEQ_QE_WRAP)
                             & ~(16'h001f << `MEQ_QE_CH_LO));
    end

    // ----------------------------------------------------------------
    // request handshake and write pointer
    // ----------------------------------------------------------------
    // masked-out requests go straight to the ack state and never touch memory
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qstate_q   <= Q_IDLE;
            qptr_q     <= {AW{1'b0}};
            ch_ack     <= 1'b0;
            entry_q    <= 16'h0000;
            last_ch_q  <= 5'h00;
            ovf_seen_q <= 1'b0;
        end else begin
            ch_ack <= 1'b0;
            if (wr_acc && is_reg(paddr, `MEQ_OFS_QPTR)) begin
                qptr_q <= pwdata[AW-1:0];
            end
            case (qstate_q)
                Q_IDLE: begin
                    if (ch_req && !ch_ack) begin // request still held in its ack cycle
                        entry_q   <= entry_d;
                        last_ch_q <= ch_num;
                        qstate_q  <= entry_pass ? Q_BUSY : Q_ACK;
                    end
                end
                Q_BUSY: begin
                    if (wr_done) begin
                        // wrap entry sends the pointer back to the base
                        qptr_q   <= wr_wrap ? qbase_q
                                  : qptr_q + {{(AW-2){1'b0}}, 2'b10};
                        qstate_q <= Q_ACK;
                    end else if (wr_ovf) begin
                        ovf_seen_q <= 1'b1; // pointer stays put
                        qstate_q   <= Q_ACK;
                    end
                end
                Q_ACK: begin
                    ch_ack   <= 1'b1;
                    qstate_q <= Q_IDLE;
                end
                default: begin
                    qstate_q <= Q_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registered memory port
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= {AW{1'b0}};
            mem_wdata <= 16'h0000;
        end else begin
            mem_req   <= w_req & ~(mem_req & mem_ack);
            mem_we    <= w_we;
            mem_addr  <= w_addr;
            mem_wdata <= w_wdata;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q   <= `MEQ_MASK_RST;
            qbase_q  <= {AW{1'b0}};
            qmask_q  <= `MEQ_QMASK_RST;
            transp_q <= 1'b0;
        end else if (wr_acc) begin
            if (is_reg(paddr, `MEQ_OFS_MASK)) begin
                mask_q <= pwdata[15:0] & `MEQ_EV_IMPL;
            end
            if (is_reg(paddr, `MEQ_OFS_QBASE)) begin
                qbase_q <= pwdata[AW-1:0];
            end
            if (is_reg(paddr, `MEQ_OFS_QMASK)) begin
                qmask_q <= pwdata[15:0];
            end
            if (ctrl_wr) begin
                transp_q <= pwdata[`MEQ_CTRL_TRANSP];
            end
        end
    end

    // ----------------------------------------------------------------
    // global fault handling of the serial engine
    // ----------------------------------------------------------------
    // restart bits are one-shot; a fault in the same cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable       <= 1'b1;
            rx_enable       <= 1'b1;
            rx_mem_write_en <= 1'b1;
        end else begin
            if (tx_fifo_underrun) begin
                tx_enable <= 1'b0; // tx line idles, rx untouched
            end else if (ctrl_wr && pwdata[`MEQ_CTRL_TX_RESTART]) begin
                tx_enable <= 1'b1;
            end
            if (rx_fifo_overrun) begin
                rx_enable       <= 1'b0;
                rx_mem_write_en <= 1'b0;
            end else if (ctrl_wr && pwdata[`MEQ_CTRL_RX_RESTART]) begin
                rx_enable       <= 1'b1;
                rx_mem_write_en <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt pending output
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else begin
            pending <= |(flags & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // apb answer: zero wait, read data latched in setup
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~(is_reg(paddr, `MEQ_OFS_EVENT)
                     | is_reg(paddr, `MEQ_OFS_MASK) | is_reg(paddr, `MEQ_OFS_QBASE)
                     | is_reg(paddr, `MEQ_OFS_QPTR) | is_reg(paddr, `MEQ_OFS_QMASK)
                     | is_reg(paddr, `MEQ_OFS_CTRL) | is_reg(paddr, `MEQ_OFS_STATUS));
            if (rd_setup) begin
                case (paddr)
                    `MEQ_OFS_EVENT:  prdata <= {16'h0000, flags & `MEQ_EV_IMPL};
                    `MEQ_OFS_MASK:   prdata <= {16'h0000, mask_q};
                    `MEQ_OFS_QBASE:  prdata <= qbase_q;
                    `MEQ_OFS_QPTR:   prdata <= qptr_q;
                    `MEQ_OFS_QMASK:  prdata <= {16'h0000, qmask_q};
                    `MEQ_OFS_CTRL:   prdata <= {29'h0000_0000, transp_q, 2'b00};
                    `MEQ_OFS_STATUS: prdata <= {20'h00000, last_ch_q, ovf_seen_q,
                                                wr_busy, rx_enable, tx_enable,
                                                qstate_q, 1'b0};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// [tb_top.sv]
// self-checking bench for the event queue block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ch_req = 0, err;
    reg ch_non_idle = 0, ch_idle = 0, tx_fifo_underrun = 0, rx_fifo_overrun = 0, mem_ack = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [4:0]  ch_num = 0;
    reg [5:0]  ch_events = 0;
    reg [15:0] mem_rdata = 0, mem [0:7];
    wire [31:0] prdata, mem_addr;
    wire [15:0] mem_wdata;
    wire pready, pslverr, ch_ack, tx_enable, rx_enable, rx_mem_write_en, pending, mem_req, mem_we;
    integer miscompares = 0, comparisons = 0;
    meq_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ch_req, .ch_num, .ch_events, .ch_non_idle, .ch_idle, .ch_ack,
        .tx_fifo_underrun, .rx_fifo_overrun, .tx_enable, .rx_enable, .rx_mem_write_en,
        .pending, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    initial forever #25 pclk = ~pclk;
    // queue memory: answers a cycle late, read data churns when idle so stale values show
    always @(posedge pclk) begin
        mem_ack <= mem_req && !mem_ack;
        if (mem_req && !mem_ack && mem_we) mem[mem_addr[3:1]] <= mem_wdata;
        mem_rdata <= (mem_req && !mem_ack && !mem_we) ? mem[mem_addr[3:1]] : ~mem_rdata;
    end
    // ----------------------------------------------------------------
    // bus and request drivers
    // ----------------------------------------------------------------
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task req(input reg [4:0] c, input reg [5:0] e, input reg ni);
        @(posedge pclk);
        {ch_req, ch_num, ch_events, ch_non_idle} <= {1'b1, c, e, ni};
        @(posedge pclk);
        while (ch_ack !== 1'b1) @(posedge pclk);
        ch_req <= 0;
    endtask
    task pulse(input reg tx);
        @(posedge pclk);
        {tx_fifo_underrun, rx_fifo_overrun} <= {tx, !tx};
        @(posedge pclk);
        {tx_fifo_underrun, rx_fifo_overrun} <= 2'b00;
        @(negedge pclk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        apb(0, 12'h000, 0); `CHK(rd, 32'h0)
        apb(1, 12'h004, 32'hffff_ffff); apb(0, 12'h004, 0); `CHK(rd, 32'h0000_00f0)
        apb(1, 12'h000, 32'hf); apb(0, 12'h000, 0); `CHK(rd, 32'h0)
        apb(0, 12'h010, 0); `CHK(rd[15:0], 16'hfc0c)
        apb(0, 12'h0f0, 0); `CHK({err, rd}, 33'h1_0000_0000)
        apb(1, 12'h004, 0);
        $display("test regs done");
    endtask
    task t_faults;
        pulse(1); `CHK({tx_enable, rx_enable, pending}, 3'b010)
        apb(1, 12'h004, 32'h40); repeat (2) @(negedge pclk); `CHK(pending, 1'b1)
        apb(1, 12'h000, 0); apb(0, 12'h000, 0); `CHK(rd[7:0], 8'h40)
        tx_fifo_underrun <= 1; apb(1, 12'h000, 32'h40); tx_fifo_underrun <= 0;
        apb(0, 12'h000, 0); `CHK(rd[7:0], 8'h40)
        apb(1, 12'h000, 32'h40); apb(0, 12'h000, 0); `CHK({pending, rd[7:0]}, 9'h0)
        pulse(0); `CHK({tx_enable, rx_enable, rx_mem_write_en}, 3'b000)
        apb(1, 12'h004, 32'h80); repeat (2) @(negedge pclk); `CHK(pending, 1'b1)
        apb(1, 12'h014, 32'h3); apb(0, 12'h000, 0); `CHK(rd[7:0], 8'h80)
        `CHK({tx_enable, rx_enable, rx_mem_write_en}, 3'b111)
        apb(1, 12'h000, 32'hc0); apb(1, 12'h004, 0);
        $display("test faults done");
    endtask
    task t_queue;
        for (int i = 0; i < 8; i++) mem[i] = (i == 2) ? 16'h0002 : 16'h0000;
        apb(1, 12'h008, 0); apb(1, 12'h00c, 0); apb(1, 12'h004, 32'h30);
        req(5, 6'h01, 0); `CHK(mem[0], 16'h04a1)
        req(31, 6'h20, 0); `CHK(mem[1], 16'h83e1)
        req(0, 6'h02, 1); `CHK(mem[2], 16'h0807)
        apb(0, 12'h00c, 0); `CHK(rd, 32'h0)
        apb(0, 12'h000, 0); `CHK({pending, rd[7:0]}, 9'h120)
        apb(1, 12'h000, 32'h20); req(7, 6'h04, 0); `CHK(mem[0], 16'h04a1)
        apb(0, 12'h000, 0); `CHK(rd[7:0], 8'h10)
        apb(0, 12'h00c, 0); `CHK(rd, 32'h0)
        mem[0] = 0; req(3, 6'h00, 0); `CHK(mem[0], 16'h0)
        apb(1, 12'h014, 32'h4); ch_idle <= 1;
        req(2, 6'h03, 1); `CHK(mem[0], 16'h0841)
        $display("test queue done");
    endtask
    task print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_faults;
        t_queue;
        print_verdict;
    end
    // tests need well under 1000 cycles; 2000 cycles means a hang
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end
endmodule
